// file: pkg/dbs_pkg.sv
/*
  constants and types of the dual bus selection cache.
  assumes a single 200 MHz node clock shared by every block around the cache.
*/
//
// Overview of operation
// (R1) downstream destination on bus A uses A
// (R2) one bus choice per whole service unit
// (R3) group and broadcast destinations go both ways
// (R4) table hit sends on indicated bus only
// (R5) table miss sends on both buses
// (R6) received unit learns source, opposite bus
// (R7) entry stamp refreshed on each new unit
// (R8) entries older than aging limit invalidated
// (R9) changed arrival bus overwrites entry bus
// (R10) loop reconfiguration invalidates whole cache
// (R11) management directive purges one chosen entry
// (R12) moved station broadcasts empty greeting both ways
// (R13) receiver needs no duplicate suppression
// (R14) head-of-bus change indication triggers table maintenance
// (R15) full cache replaces entry with oldest stamp
package dbs_pkg;

  // ----------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------
  localparam int ADDR_W    = 48;
  localparam int ENTRIES   = 8;
  localparam int STAMP_W   = 16;
  // individual/group flag position inside the address word
  localparam int GROUP_BIT = 40;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ     = 200_000;
  localparam int TICK_MS     = 1;
  localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
  // aging limit after reset, in ticks (a few seconds)
  localparam logic [STAMP_W-1:0] AGE_RESET = 16'h0BB8;

  // ----------------------------------------------------------------
  // bus decision carried through the output buffer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic hit;
    logic bus_a;
    logic bus_b;
  } dbs_sel_t;

endpackage : dbs_pkg

// file: pkg/dbs_stream_if.sv
/*
  valid/ready stream carrying bus decisions between cache and buffer.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface dbs_stream_if;
  dbs_pkg::dbs_sel_t data;
  logic              valid;
  logic              ready;

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : dbs_stream_if

// file: design/dbs_pair_buf.sv
/*
  two-entry buffer with registered valid, ready and head data.
  assumes the sink may stall for any number of cycles.
*/
`timescale 1ns/1ps
module dbs_pair_buf (
  input  wire logic   clk,
  input  wire logic   sys_rst,
  dbs_stream_if.snk   in_s,
  dbs_stream_if.src   out_s
);

  dbs_pkg::dbs_sel_t head_q;
  dbs_pkg::dbs_sel_t tail_q;
  logic [1:0]        cnt_q;
  logic [1:0]        cnt_d;
  logic              ready_q;
  logic              valid_q;
  logic              push;
  logic              pop;

  assign push        = in_s.valid & ready_q;
  assign pop         = valid_q & out_s.ready;
  assign in_s.ready  = ready_q;
  assign out_s.valid = valid_q;
  assign out_s.data  = head_q;

  // ----------------------------------------------------------------
  // occupancy
  // ----------------------------------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  // flags are registered so neither side sees a combinational path
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q   <= 2'h0;
      ready_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      ready_q <= (cnt_d != 2'h2);
      valid_q <= (cnt_d != 2'h0);
    end
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      head_q <= '0;
      tail_q <= '0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (cnt_q == 2'h0) begin
            head_q <= in_s.data;
          end else begin
            tail_q <= in_s.data;
          end
        end
        2'b01: begin
          head_q <= tail_q;
        end
        2'b11: begin
          if (cnt_q == 2'h1) begin
            head_q <= in_s.data;
          end else begin
            head_q <= tail_q;
            tail_q <= in_s.data;
          end
        end
        default: begin
          head_q <= head_q;
        end
      endcase
    end
  end

endmodule : dbs_pair_buf

// file: design/dbs_cache.sv
/*
  bus selection cache: per service unit decides bus A, bus B or both,
  learns source addresses from received initial units, ages, amends and
  purges entries.
  assumes request, receive and management inputs come from logic on clk,
  and that the queued arbitrated block applies one decision to every
  derived segment unit of the service unit it belongs to.
*/
`timescale 1ns/1ps
module dbs_cache #(
  parameter int ENTRIES     = dbs_pkg::ENTRIES,
  parameter int TICK_CYCLES = dbs_pkg::TICK_CYCLES
) (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  // destination lookup from the service convergence unit
  input  wire logic                        req_valid,
  output wire logic                        req_ready,
  input  wire logic [dbs_pkg::ADDR_W-1:0]  req_dest_addr,
  // decision toward queued arbitrated access
  output wire logic                        sel_valid,
  input  wire logic                        sel_ready,
  output wire logic                        sel_bus_a,
  output wire logic                        sel_bus_b,
  output wire logic                        sel_hit,
  // received initial protocol units
  input  wire logic                        rx_valid,
  input  wire logic [dbs_pkg::ADDR_W-1:0]  rx_src_addr,
  input  wire logic                        rx_on_bus_b,
  input  wire logic                        rx_dest_local,
  input  wire logic                        learn_all,
  // maintenance
  input  wire logic [dbs_pkg::STAMP_W-1:0] age_limit,
  input  wire logic                        hob_changed,
  input  wire logic                        purge_valid,
  input  wire logic [dbs_pkg::ADDR_W-1:0]  purge_addr,
  output wire logic                        purge_done,
  output wire logic                        purge_hit
);

  localparam int IDX_W = $clog2(ENTRIES);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (ENTRIES < 2) begin : g_bad_entries
    $error("ENTRIES must be at least 2");
  end
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  // ----------------------------------------------------------------
  // table storage
  // ----------------------------------------------------------------
  logic [dbs_pkg::ADDR_W-1:0]  addr_q  [ENTRIES];
  logic [dbs_pkg::STAMP_W-1:0] stamp_q [ENTRIES];
  logic [ENTRIES-1:0]          valid_q;
  logic [ENTRIES-1:0]          use_b_q;

  function automatic logic [ENTRIES-1:0] match_vec(
    input logic [dbs_pkg::ADDR_W-1:0] a,
    input logic [ENTRIES-1:0]         v
  );
    logic [ENTRIES-1:0] m;
    m = '0;
    for (int i = 0; i < ENTRIES; i++) begin
      m[i] = v[i] && (addr_q[i] == a);
    end
    return m;
  endfunction : match_vec

  function automatic logic [IDX_W-1:0] first_idx(input logic [ENTRIES-1:0] m);
    logic [IDX_W-1:0] k;
    k = '0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (m[i]) begin
        k = IDX_W'(i);
      end
    end
    return k;
  endfunction : first_idx

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  logic [$clog2(TICK_CYCLES)-1:0] div_q;
  logic                           tick_q;
  logic [dbs_pkg::STAMP_W-1:0]    now_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (div_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) begin
      div_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      now_q <= '0;
    end else if (tick_q) begin
      now_q <= now_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // lookup
  // ----------------------------------------------------------------
  dbs_stream_if lk_s ();
  dbs_stream_if out_s ();

  logic [ENTRIES-1:0] lk_match;
  logic [IDX_W-1:0]   lk_idx;
  logic               lk_group;
  dbs_pkg::dbs_sel_t  lk_sel;

  // always_comb, not assign: the compare function reads the address table,
  // which a continuous assignment would not track when only an address moves
  always_comb begin
    lk_match = match_vec(req_dest_addr, valid_q);
  end
  assign lk_idx   = first_idx(lk_match);
  assign lk_group = req_dest_addr[dbs_pkg::GROUP_BIT];

  // a unit sent both ways reaches each receiver only once, since a
  // receiver sits downstream on exactly one bus  [R13]
  always_comb begin
    lk_sel = '0;
    if (lk_group) begin
      lk_sel.bus_a = 1'b1;                          // [R3]
      lk_sel.bus_b = 1'b1;                          // [R3]
    end else if (|lk_match) begin
      lk_sel.hit   = 1'b1;
      lk_sel.bus_a = ~use_b_q[lk_idx];              // [R1] [R4]
      lk_sel.bus_b = use_b_q[lk_idx];               // [R1] [R4]
    end else begin
      lk_sel.bus_a = 1'b1;                          // [R5]
      lk_sel.bus_b = 1'b1;                          // [R5]
    end
  end

  // one decision per request covers every derived segment unit  [R2]
  assign lk_s.data  = lk_sel;
  assign lk_s.valid = req_valid;
  assign req_ready  = lk_s.ready;

  dbs_pair_buf u_buf (
    .clk     (clk),
    .sys_rst (sys_rst),
    .in_s    (lk_s),
    .out_s   (out_s)
  );

  assign sel_valid   = out_s.valid;
  assign out_s.ready = sel_ready;
  assign sel_bus_a   = out_s.data.bus_a;
  assign sel_bus_b   = out_s.data.bus_b;
  assign sel_hit     = out_s.data.hit;

  // ----------------------------------------------------------------
  // learning and victim choice
  // ----------------------------------------------------------------
  logic                      learn;
  logic [ENTRIES-1:0]        rx_match;
  logic [IDX_W-1:0]          victim;
  logic [IDX_W-1:0]          learn_idx;
  logic [ENTRIES-1:0]        expired;
  logic [ENTRIES-1:0]        pg_match;

  // group sources are never learned; learning scope is selectable  [R6]
  assign learn    = rx_valid && !rx_src_addr[dbs_pkg::GROUP_BIT]
                    && (learn_all || rx_dest_local);
  // a replaced victim keeps its valid bit, so only the table read itself
  // can wake these compares
  always_comb begin
    rx_match = match_vec(rx_src_addr, valid_q);
  end

  always_comb begin
    pg_match = match_vec(purge_addr, valid_q);
  end

  // free slot first, otherwise the oldest stamp  [R15]
  always_comb begin
    logic [dbs_pkg::STAMP_W-1:0] best_age;
    logic [dbs_pkg::STAMP_W-1:0] age;
    logic                        free_found;
    best_age   = '0;
    age        = '0;
    free_found = 1'b0;
    victim     = '0;
    for (int i = 0; i < ENTRIES; i++) begin
      age = now_q - stamp_q[i];
      if (!valid_q[i] && !free_found) begin
        free_found = 1'b1;
        victim     = IDX_W'(i);
      end else if (!free_found && age > best_age) begin
        best_age = age;
        victim   = IDX_W'(i);                       // [R15]
      end
    end
  end

  assign learn_idx = (|rx_match) ? first_idx(rx_match) : victim;

  for (genvar g = 0; g < ENTRIES; g++) begin : g_age
    assign expired[g] = valid_q[g]
                        && ((now_q - stamp_q[g]) >= age_limit);   // [R8]
  end

  // ----------------------------------------------------------------
  // address, bus and stamp
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      use_b_q <= '0;
      for (int i = 0; i < ENTRIES; i++) begin
        addr_q[i]  <= '0;
        stamp_q[i] <= '0;
      end
    end else if (learn) begin
      addr_q[learn_idx]  <= rx_src_addr;              // [R6]
      // arrival on A means the source is upstream on A: answer on B
      use_b_q[learn_idx] <= ~rx_on_bus_b;             // [R6] [R9]
      stamp_q[learn_idx] <= now_q;                    // [R7]
    end
  end

  // ----------------------------------------------------------------
  // validity: reconfiguration beats purge beats learning beats aging
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      valid_q <= '0;
    end else if (hob_changed) begin
      // a possible head-of-bus move invalidates every entry  [R10] [R14]
      valid_q <= '0;
    end else begin
      for (int i = 0; i < ENTRIES; i++) begin
        if (purge_valid && pg_match[i]) begin
          valid_q[i] <= 1'b0;                        // [R11]
        end else if (learn && IDX_W'(i) == learn_idx) begin
          // a fresh unit keeps the entry alive even at its limit
          valid_q[i] <= 1'b1;                        // [R6] [R7]
        end else if (expired[i]) begin
          valid_q[i] <= 1'b0;                        // [R8]
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // purge acknowledge
  // ----------------------------------------------------------------
  logic purge_done_q;
  logic purge_hit_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      purge_done_q <= 1'b0;
      purge_hit_q  <= 1'b0;
    end else begin
      purge_done_q <= purge_valid;                    // [R11]
      purge_hit_q  <= purge_valid && (|pg_match);     // [R11]
    end
  end

  assign purge_done = purge_done_q;
  assign purge_hit  = purge_hit_q;

  // relocated stations announce themselves with an empty greeting; it
  // arrives as an ordinary received unit and relearns here  [R12]

endmodule : dbs_cache

// file: verif/dbs_qa_model.sv
/*
  queued arbitrated side model: takes bus decisions, may stall or run slow.
  assumes the cache drives its decision outputs from flops on clk.
*/
`timescale 1ns/1ps
module dbs_qa_model (
  input  wire logic clk,
  input  wire logic stall,
  input  wire logic slow,
  input  wire logic sel_valid,
  input  wire logic sel_bus_a,
  input  wire logic sel_bus_b,
  input  wire logic sel_hit,
  output wire logic sel_ready
);
  // ----------------------------------------------------------------
  // accept path
  // ----------------------------------------------------------------
  logic       ph_q = 1'b0;
  logic [2:0] got[$];
  // slow mode refuses every other cycle, as a busy arbiter would
  assign sel_ready = !stall && !(slow && ph_q);
  // one decision governs every derived segment unit of a service unit
  // a two-bus send is kept once here, the far receiver sees one copy
  always @(posedge clk) begin
    ph_q <= ~ph_q;
    if (sel_valid && sel_ready) got.push_back({sel_hit, sel_bus_a, sel_bus_b});
  end
endmodule : dbs_qa_model

// file: verif/dbs_cache_checker.sv
/*
  port-level assertions for the bus selection cache.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module dbs_cache_checker (
  input wire logic                        clk,
  input wire logic                        sys_rst,
  input wire logic                        req_valid,
  input wire logic                        req_ready,
  input wire logic [dbs_pkg::ADDR_W-1:0]  req_dest_addr,
  input wire logic                        sel_valid,
  input wire logic                        sel_ready,
  input wire logic                        sel_bus_a,
  input wire logic                        sel_bus_b,
  input wire logic                        sel_hit,
  input wire logic                        rx_valid,
  input wire logic [dbs_pkg::ADDR_W-1:0]  rx_src_addr,
  input wire logic                        rx_on_bus_b,
  input wire logic                        rx_dest_local,
  input wire logic                        learn_all,
  input wire logic [dbs_pkg::STAMP_W-1:0] age_limit,
  input wire logic                        hob_changed,
  input wire logic                        purge_valid,
  input wire logic [dbs_pkg::ADDR_W-1:0]  purge_addr,
  input wire logic                        purge_done,
  input wire logic                        purge_hit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // decisions
  // ----------------------------------------------------------------
  a_answer_next: assert property (req_valid && req_ready && !sel_valid |=> sel_valid)
    else $error("decision late");
  a_group_both: assert property (req_valid && req_ready && !sel_valid &&
    req_dest_addr[dbs_pkg::GROUP_BIT] |=> sel_valid && sel_bus_a && sel_bus_b && !sel_hit)
    else $error("group not both");
  a_sel_stands: assert property (sel_valid && !sel_ready |=>
    sel_valid && $stable({sel_bus_a, sel_bus_b, sel_hit})) else $error("decision moved");
  a_hit_one_bus: assert property (sel_valid && sel_hit |-> sel_bus_a != sel_bus_b)
    else $error("hit on both");
  a_miss_both: assert property (sel_valid && !sel_hit |-> sel_bus_a && sel_bus_b)
    else $error("miss not both");
  a_refuse_full: assert property (req_valid && req_ready && sel_valid && !sel_ready
    |=> !req_ready) else $error("full buffer took request");
  // ----------------------------------------------------------------
  // purge
  // ----------------------------------------------------------------
  a_purge_done: assert property (purge_valid |=> purge_done)
    else $error("purge not answered");
  a_purge_hit: assert property (purge_hit |-> purge_done && $past(purge_valid))
    else $error("stray purge hit");
endmodule : dbs_cache_checker

bind dbs_cache dbs_cache_checker chk_i (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
  .req_ready(req_ready), .req_dest_addr(req_dest_addr), .sel_valid(sel_valid),
  .sel_ready(sel_ready), .sel_bus_a(sel_bus_a), .sel_bus_b(sel_bus_b), .sel_hit(sel_hit),
  .rx_valid(rx_valid), .rx_src_addr(rx_src_addr), .rx_on_bus_b(rx_on_bus_b),
  .rx_dest_local(rx_dest_local), .learn_all(learn_all), .age_limit(age_limit),
  .hob_changed(hob_changed), .purge_valid(purge_valid), .purge_addr(purge_addr),
  .purge_done(purge_done), .purge_hit(purge_hit));

// file: verif/dbs_cache_tb.sv
/*
  self-checking bench for the bus selection cache with a stalling arbiter model.
  assumes four entries and a ten-cycle aging tick.
*/
`timescale 1ns/1ps
module dbs_cache_tb;
  localparam logic [3:0]  MISS  = 4'h3;
  localparam logic [3:0]  HIT_A = 4'h6;
  localparam logic [3:0]  HIT_B = 4'h5;
  localparam logic [47:0] UA    = 48'h0000_0000_1000;
  localparam logic [47:0] GA    = 48'h0100_0000_0001;
  logic clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, rx_valid = 1'b0, rx_on_bus_b = 1'b0;
  logic rx_dest_local = 1'b1, learn_all = 1'b0, hob_changed = 1'b0, purge_valid = 1'b0;
  logic stall = 1'b0, slow = 1'b0;
  logic req_ready, sel_valid, sel_ready, sel_bus_a, sel_bus_b, sel_hit, purge_done, purge_hit;
  logic [47:0] req_dest_addr = '0, rx_src_addr = '0, purge_addr = '0;
  logic [15:0] age_limit = dbs_pkg::AGE_RESET;
  int          err_count = 0, n_checks = 0;

  always #2.5 clk = ~clk;
  dbs_cache #(.ENTRIES(4), .TICK_CYCLES(10)) dut (.clk(clk), .sys_rst(sys_rst),
    .req_valid(req_valid), .req_ready(req_ready), .req_dest_addr(req_dest_addr),
    .sel_valid(sel_valid), .sel_ready(sel_ready), .sel_bus_a(sel_bus_a),
    .sel_bus_b(sel_bus_b), .sel_hit(sel_hit), .rx_valid(rx_valid), .rx_src_addr(rx_src_addr),
    .rx_on_bus_b(rx_on_bus_b), .rx_dest_local(rx_dest_local), .learn_all(learn_all),
    .age_limit(age_limit), .hob_changed(hob_changed), .purge_valid(purge_valid),
    .purge_addr(purge_addr), .purge_done(purge_done), .purge_hit(purge_hit));
  dbs_qa_model qa (.clk(clk), .stall(stall), .slow(slow), .sel_valid(sel_valid),
    .sel_bus_a(sel_bus_a), .sel_bus_b(sel_bus_b), .sel_hit(sel_hit), .sel_ready(sel_ready));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic send(input logic [47:0] a);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_dest_addr <= a;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 200);
    req_valid <= 1'b0;
  endtask : send
  task automatic take(input logic [3:0] exp);
    int n;
    logic [2:0] d;
    n = 0;
    d = 'x;
    while (qa.got.size() == 0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (qa.got.size() > 0) d = qa.got.pop_front();
    chk({1'b0, d}, exp);
  endtask : take
  task automatic look(input logic [47:0] a, input logic [3:0] exp);
    send(a);
    take(exp);
  endtask : look
  // an arrival on bus A teaches bus B for the way back
  task automatic rx(input logic [47:0] a, input logic b);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_src_addr <= a;
    rx_on_bus_b <= b;
    @(posedge clk);
    rx_valid <= 1'b0;
  endtask : rx
  task automatic purge(input logic [47:0] a, input logic [3:0] exp);
    @(posedge clk);
    purge_valid <= 1'b1;
    purge_addr <= a;
    @(posedge clk);
    purge_valid <= 1'b0;
    #1;
    chk({2'h0, purge_done, purge_hit}, exp);
    @(posedge clk);
  endtask : purge
  task automatic hob();
    @(posedge clk);
    hob_changed <= 1'b1;
    @(posedge clk);
    hob_changed <= 1'b0;
  endtask : hob

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_basic();
    look(UA, MISS);
    look(GA, MISS);
    rx(UA, 1'b0);
    look(UA, HIT_B);
    rx(UA + 48'h1, 1'b1);
    look(UA + 48'h1, HIT_A);
    rx(UA, 1'b1); // greeting from a moved station
    look(UA, HIT_A);
    purge(UA, 4'h3);
    look(UA, MISS);
    purge(UA, 4'h2);
  endtask : t_basic
  task automatic t_policy();
    rx_dest_local <= 1'b0;
    rx(UA + 48'h2, 1'b0);
    look(UA + 48'h2, MISS);
    learn_all <= 1'b1;
    rx(UA + 48'h2, 1'b0);
    look(UA + 48'h2, HIT_B);
    rx_dest_local <= 1'b1;
    learn_all <= 1'b0;
    hob();
    look(UA + 48'h1, MISS);
  endtask : t_policy
  task automatic t_age();
    age_limit <= 16'h0003;
    rx(UA + 48'h3, 1'b0);
    repeat (12) @(posedge clk);
    look(UA + 48'h3, HIT_B);
    rx(UA + 48'h3, 1'b0);
    repeat (12) @(posedge clk);
    look(UA + 48'h3, HIT_B);
    repeat (40) @(posedge clk);
    look(UA + 48'h3, MISS);
    age_limit <= dbs_pkg::AGE_RESET;
  endtask : t_age
  task automatic t_full();
    hob();
    for (int i = 0; i < 5; i++) begin
      rx(UA + 48'(i), 1'b0);
      repeat (12) @(posedge clk);
    end
    look(UA, MISS);
    look(UA + 48'h1, HIT_B);
    look(UA + 48'h4, HIT_B);
  endtask : t_full
  // the arbiter stalls while two decisions pile up, then drains slowly
  task automatic t_stall();
    stall <= 1'b1;
    send(UA + 48'h1);
    send(UA + 48'h9);
    repeat (3) @(posedge clk);
    #1;
    chk({3'h0, req_ready}, 4'h0);
    @(posedge clk);
    stall <= 1'b0;
    slow <= 1'b1;
    take(HIT_B);
    take(MISS);
    slow <= 1'b0;
  endtask : t_stall

  initial begin
    #100000;
    err_count++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_basic();
    t_policy();
    t_age();
    t_full();
    t_stall();
    end_sim();
  end
endmodule : dbs_cache_tb
